// ===== rtl/dam_addr_map.sv
// data memory address map: internal ram, special registers, stack,
// bit area, on-chip external ram and the off-chip access path
// assumes one request at a time from the core, taken while req_ready is high
`timescale 1ns/100ps

module dam_addr_map (
  // clock and reset
  input  logic                   clk,
  input  logic                   rstn,
  // core request
  input  logic                   req_valid,
  input  dam_pkg::dam_req_t      req,
  output logic                   req_ready,
  // answer
  output logic                   rsp_valid,
  output logic [7:0]             rsp_data,
  output logic                   rsp_bit,
  // program memory
  input  logic [15:0]            prog_fetch_addr,
  output logic                   prog_fetch_reserved,
  output logic                   pmem_wr_valid,
  output logic                   pmem_wr_reserved,
  output logic [15:0]            pmem_wr_addr,
  output logic [7:0]             pmem_wr_data,
  // port latches, crossbar and output modes
  input  dam_pkg::dam_port_bus_t latch_out,
  input  dam_pkg::dam_port_bus_t latch_oe,
  input  dam_pkg::dam_port_bus_t port_output_mode,
  // pins
  input  dam_pkg::dam_port_bus_t pins_in,
  output dam_pkg::dam_port_bus_t pins_out,
  output dam_pkg::dam_port_bus_t pins_oe,
  output dam_pkg::dam_port_bus_t pins_mode
);
  import dam_pkg::*;

  typedef enum logic [1:0] {
    DAM_S_IDLE = 2'b01,
    DAM_S_EXT  = 2'b10
  } dam_cstate_t;

  typedef struct packed {
    dam_cstate_t  st;
    logic [7:0]   stack_pointer;
    logic [7:0]   external_data_ram_page_select;
    logic [7:0]   data_pointer_low;
    logic [7:0]   data_pointer_high;
    logic [7:0]   program_status_word;
    logic         program_store_control;
    logic [7:0]   interface_configuration;
    logic         rsp_valid;
    logic [7:0]   rsp_data;
    logic         rsp_bit;
    logic         pm_valid;
    logic         pm_res;
    logic [15:0]  pm_addr;
    logic [7:0]   pm_data;
    logic         fetch_res;
    dam_ext_req_t ext;
  } dam_core_state_t;

  // internal ram and on-chip external ram
  logic [7:0] iram [256];
  logic [7:0] external_data_ram [1 << DAM_EXTERNAL_DATA_RAM_AW];

  dam_core_state_t s_reg;
  dam_core_state_t s_next;

  logic                   ram_we;
  logic [7:0]             ram_wa;
  logic [7:0]             ram_wd;
  logic                   external_data_ram_we;
  logic [DAM_EXTERNAL_DATA_RAM_AW-1:0] external_data_ram_a;
  logic [7:0]             external_data_ram_wd;
  logic                   sfr_we;
  logic [7:0]             sfr_wa;
  logic [7:0]             sfr_wd;
  logic [7:0]             ptr;
  logic [7:0]             cur;
  logic [7:0]             byte_a;
  logic [15:0]            xa;
  logic                   onchip;
  dam_xmode_t             xmode;
  logic                   ext_done;
  logic [7:0]             ext_rdata;

  // address of index register a or b inside the active bank
  function automatic logic [7:0] index_addr(input logic [7:0] status, input logic b);
    logic [1:0] bank;
    bank = status[DAM_STATUS_BANK_LSB +: 2];
    return {3'h0, bank, 2'h0, b};
  endfunction : index_addr

  // special register read view; reserved bits and unmapped offsets read zero
  function automatic logic [7:0] sfr_rd(input dam_core_state_t s, input logic [7:0] a);
    logic [7:0] v;
    v = DAM_ZERO_BYTE;
    case (a)
      DAM_SFR_STACK:     v = s.stack_pointer;
      DAM_SFR_PTR_LOW:   v = s.data_pointer_low;
      DAM_SFR_PTR_HIGH:  v = s.data_pointer_high;
      DAM_SFR_PAGE:      v = s.external_data_ram_page_select;
      DAM_SFR_STATUS:    v = s.program_status_word;
      DAM_SFR_STORE_CTL: v[DAM_STORE_WE_BIT] = s.program_store_control;
      DAM_SFR_EMICF:     v = s.interface_configuration;
      default:           v = DAM_ZERO_BYTE;
    endcase
    return v;
  endfunction : sfr_rd

  always_comb begin
    s_next           = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.pm_valid  = 1'b0;
    s_next.pm_res    = 1'b0;
    s_next.ext.start = 1'b0;
    s_next.fetch_res = (prog_fetch_addr > DAM_PROG_TOP);
    ram_we  = 1'b0;
    ram_wa  = DAM_ZERO_BYTE;
    ram_wd  = DAM_ZERO_BYTE;
    external_data_ram_we = 1'b0;
    external_data_ram_a  = '0;
    external_data_ram_wd = DAM_ZERO_BYTE;
    sfr_we  = 1'b0;
    sfr_wa  = DAM_ZERO_BYTE;
    sfr_wd  = DAM_ZERO_BYTE;
    ptr     = iram[index_addr(s_reg.program_status_word, req.idx_b)];
    cur     = DAM_ZERO_BYTE;
    byte_a  = DAM_ZERO_BYTE;
    xmode   = dam_xmode_t'(s_reg.interface_configuration[DAM_EMICF_MD_LSB +: 2]);
    // the page byte is read from the register here, so a write counts from the next request on
    xa      = (req.kind == DAM_K_XPAGE) ? {s_reg.external_data_ram_page_select, ptr}
                                        : {s_reg.data_pointer_high, s_reg.data_pointer_low};
    onchip  = (xmode == DAM_XM_ONCHIP) ||
              ((xmode != DAM_XM_OFFCHIP) && (xa[15:DAM_EXTERNAL_DATA_RAM_AW] == '0));
    case (s_reg.st)
      DAM_S_IDLE: begin
        if (req_valid) begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_bit   = 1'b0;
          case (req.kind)
            DAM_K_DIRECT: begin
              if (req.addr[7]) begin
                s_next.rsp_data = sfr_rd(s_reg, req.addr);
                sfr_we = req.write;
                sfr_wa = req.addr;
                sfr_wd = req.wdata;
              end else begin
                s_next.rsp_data = iram[req.addr];
                ram_we = req.write;
                ram_wa = req.addr;
                ram_wd = req.wdata;
              end
            end
            DAM_K_INDIRECT: begin
              s_next.rsp_data = iram[ptr];
              ram_we = req.write;
              ram_wa = ptr;
              ram_wd = req.wdata;
            end
            DAM_K_BIT: begin
              if (req.addr[7]) begin
                byte_a = {req.addr[7:3], 3'h0};
                cur    = sfr_rd(s_reg, byte_a);
              end else begin
                byte_a = DAM_BIT_BASE + {4'h0, req.addr[6:3]};
                cur    = iram[byte_a];
              end
              s_next.rsp_bit  = cur[req.addr[2:0]];
              s_next.rsp_data = cur;
              cur[req.addr[2:0]] = req.wdata[0];
              if (req.addr[7]) begin
                sfr_we = req.write;
                sfr_wa = byte_a;
                sfr_wd = cur;
              end else begin
                ram_we = req.write;
                ram_wa = byte_a;
                ram_wd = cur;
              end
            end
            DAM_K_PUSH: begin
              ram_we = 1'b1;
              ram_wa = s_reg.stack_pointer + DAM_ONE_BYTE;
              ram_wd = req.wdata;
              s_next.stack_pointer = s_reg.stack_pointer + DAM_ONE_BYTE;
            end
            DAM_K_POP: begin
              s_next.rsp_data      = iram[s_reg.stack_pointer];
              s_next.stack_pointer = s_reg.stack_pointer - DAM_ONE_BYTE;
            end
            DAM_K_XDPTR, DAM_K_XPAGE: begin
              if (req.write && s_reg.program_store_control) begin
                s_next.pm_addr  = xa;
                s_next.pm_data  = req.wdata;
                s_next.pm_valid = (xa <= DAM_PROG_TOP);
                s_next.pm_res   = (xa > DAM_PROG_TOP);
              end else if (onchip) begin
                external_data_ram_a  = xa[DAM_EXTERNAL_DATA_RAM_AW-1:0];
                external_data_ram_we = req.write;
                external_data_ram_wd = req.wdata;
                s_next.rsp_data = external_data_ram[external_data_ram_a];
              end else begin
                s_next.rsp_valid   = 1'b0;
                s_next.st          = DAM_S_EXT;
                s_next.ext.start   = 1'b1;
                s_next.ext.write   = req.write;
                s_next.ext.addr    = xa;
                s_next.ext.wdata   = req.wdata;
                s_next.ext.mux     = !s_reg.interface_configuration[DAM_EMICF_MUX_BIT];
                // without bank select the page byte stays off the high pins
                s_next.ext.high_en = !((xmode == DAM_XM_SPLIT) && (req.kind == DAM_K_XPAGE));
              end
            end
            default: s_next.rsp_data = DAM_ZERO_BYTE;
          endcase
        end
      end
      DAM_S_EXT: begin
        if (ext_done) begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = ext_rdata;
          s_next.st        = DAM_S_IDLE;
        end
      end
      default: s_next.st = DAM_S_IDLE;
    endcase
    // special register writes
    if (sfr_we) begin
      case (sfr_wa)
        DAM_SFR_STACK:     s_next.stack_pointer = sfr_wd;
        DAM_SFR_PTR_LOW:   s_next.data_pointer_low = sfr_wd;
        DAM_SFR_PTR_HIGH:  s_next.data_pointer_high = sfr_wd;
        DAM_SFR_PAGE:      s_next.external_data_ram_page_select = sfr_wd;
        DAM_SFR_STATUS:    s_next.program_status_word = sfr_wd;
        DAM_SFR_STORE_CTL: s_next.program_store_control = sfr_wd[DAM_STORE_WE_BIT];
        DAM_SFR_EMICF:     s_next.interface_configuration = sfr_wd & DAM_EMICF_MASK;
        default:           s_next.st = s_next.st;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{
        st:                      DAM_S_IDLE,
        stack_pointer:           DAM_STACK_RESET,
        external_data_ram_page_select:        DAM_PAGE_RESET,
        interface_configuration: DAM_EMICF_RESET,
        default:                 '0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // memories carry no reset; contents are undefined at power-up
  always_ff @(posedge clk) begin
    if (ram_we) begin
      iram[ram_wa] <= ram_wd;
    end
    if (external_data_ram_we) begin
      external_data_ram[external_data_ram_a] <= external_data_ram_wd;
    end
  end

  dam_ext_if u_ext (
    .clk       (clk),
    .rstn      (rstn),
    .ext       (s_reg.ext),
    .done      (ext_done),
    .rdata     (ext_rdata),
    .latch_out (latch_out),
    .latch_oe  (latch_oe),
    .mode_in   (port_output_mode),
    .pins_in   (pins_in),
    .pins_out  (pins_out),
    .pins_oe   (pins_oe),
    .mode_out  (pins_mode)
  );

  // stalls for the whole off-chip transfer; internal accesses never stall
  assign req_ready           = (s_reg.st == DAM_S_IDLE);
  assign rsp_valid           = s_reg.rsp_valid;
  assign rsp_data            = s_reg.rsp_data;
  assign rsp_bit             = s_reg.rsp_bit;
  assign prog_fetch_reserved = s_reg.fetch_res;
  assign pmem_wr_valid       = s_reg.pm_valid;
  assign pmem_wr_reserved    = s_reg.pm_res;
  assign pmem_wr_addr        = s_reg.pm_addr;
  assign pmem_wr_data        = s_reg.pm_data;

endmodule : dam_addr_map

// ===== rtl/dam_ext_if.sv
// off-chip access sequencer: claims port pins only while a transfer runs
// assumes pins_in is synchronous and port latches park pins high between accesses
`timescale 1ns/100ps
module dam_ext_if (
  // clock and reset
  input  logic                   clk,
  input  logic                   rstn,
  // request from the address map
  input  dam_pkg::dam_ext_req_t  ext,
  output logic                   done,
  output logic [7:0]             rdata,
  // port latches, crossbar enables and output modes
  input  dam_pkg::dam_port_bus_t latch_out,
  input  dam_pkg::dam_port_bus_t latch_oe,
  input  dam_pkg::dam_port_bus_t mode_in,
  // pins
  input  dam_pkg::dam_port_bus_t pins_in,
  output dam_pkg::dam_port_bus_t pins_out,
  output dam_pkg::dam_port_bus_t pins_oe,
  output dam_pkg::dam_port_bus_t mode_out
);
  import dam_pkg::*;

  typedef enum logic [3:0] {
    DAM_E_IDLE = 4'b0001,
    DAM_E_ALE  = 4'b0010,
    DAM_E_HOLD = 4'b0100,
    DAM_E_STB  = 4'b1000
  } dam_estate_t;

  typedef struct packed {
    dam_estate_t   st;
    logic [1:0]    cnt;
    dam_ext_req_t  req;
    logic          done;
    logic [7:0]    rdata;
    dam_port_bus_t po;
    dam_port_bus_t oe;
    dam_port_bus_t md;
  } dam_ext_state_t;

  dam_ext_state_t s_reg;
  dam_ext_state_t s_next;
  logic           own;
  logic           stb;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    s_next.md   = mode_in;
    case (s_reg.st)
      DAM_E_IDLE: begin
        if (ext.start) begin
          s_next.req = ext;
          s_next.cnt = 2'h0;
          s_next.st  = ext.mux ? DAM_E_ALE : DAM_E_STB;
        end
      end
      DAM_E_ALE:  s_next.st = DAM_E_HOLD;
      DAM_E_HOLD: s_next.st = DAM_E_STB;
      DAM_E_STB: begin
        if (s_reg.cnt == DAM_STB_LAST) begin
          s_next.done = 1'b1;
          s_next.st   = DAM_E_IDLE;
          if (!s_reg.req.write) begin
            s_next.rdata = pins_in.p4;
          end
        end else begin
          s_next.cnt = s_reg.cnt + 2'h1;
        end
      end
      default: s_next.st = DAM_E_IDLE;
    endcase
    // pins follow the latches unless a transfer owns them
    own       = (s_next.st != DAM_E_IDLE);
    stb       = (s_next.st == DAM_E_STB);
    s_next.po = latch_out;
    s_next.oe = latch_oe;
    if (own) begin
      s_next.po.p1[DAM_P1_WR_BIT] = !(stb && s_next.req.write);
      s_next.po.p1[DAM_P1_RD_BIT] = !(stb && !s_next.req.write);
      s_next.oe.p1[DAM_P1_WR_BIT] = 1'b1;
      s_next.oe.p1[DAM_P1_RD_BIT] = 1'b1;
      if (s_next.req.high_en) begin
        s_next.po.p2 = s_next.req.addr[15:8];
        s_next.oe.p2 = 8'hFF;
      end
      if (s_next.req.mux) begin
        s_next.po.p1[DAM_P1_ALE_BIT] = (s_next.st == DAM_E_ALE);
        s_next.oe.p1[DAM_P1_ALE_BIT] = 1'b1;
        s_next.po.p4 = stb ? s_next.req.wdata : s_next.req.addr[7:0];
        s_next.oe.p4 = {8{!stb || s_next.req.write}};
      end else begin
        s_next.po.p3 = s_next.req.addr[7:0];
        s_next.oe.p3 = 8'hFF;
        s_next.po.p4 = s_next.req.wdata;
        s_next.oe.p4 = {8{s_next.req.write}};
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{st: DAM_E_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign done     = s_reg.done;
  assign rdata    = s_reg.rdata;
  assign pins_out = s_reg.po;
  assign pins_oe  = s_reg.oe;
  assign mode_out = s_reg.md;

endmodule : dam_ext_if

// ===== rtl/dam_pkg.sv
// shared constants, encodings and carriers for the data memory address map
// assumes a single 25 MHz clock domain and an active-low asynchronous reset
package dam_pkg;

  // special register offsets in the direct space above the lower ram
  localparam logic [7:0] DAM_SFR_STACK     = 8'h81;
  localparam logic [7:0] DAM_SFR_PTR_LOW   = 8'h82;
  localparam logic [7:0] DAM_SFR_PTR_HIGH  = 8'h83;
  localparam logic [7:0] DAM_SFR_EMICF     = 8'h85;
  localparam logic [7:0] DAM_SFR_STORE_CTL = 8'h8F;
  localparam logic [7:0] DAM_SFR_PAGE      = 8'hAA;
  localparam logic [7:0] DAM_SFR_STATUS    = 8'hD0;

  // reset values and masks
  localparam logic [7:0] DAM_STACK_RESET = 8'h07;
  localparam logic [7:0] DAM_PAGE_RESET  = 8'h00;
  localparam logic [7:0] DAM_ZERO_BYTE   = 8'h00;
  localparam logic [7:0] DAM_EMICF_RESET = 8'h03;
  localparam logic [7:0] DAM_EMICF_MASK  = 8'h1F;
  localparam logic [7:0] DAM_ONE_BYTE    = 8'h01;

  // field positions
  localparam int DAM_STATUS_BANK_LSB = 3;
  localparam int DAM_EMICF_MUX_BIT   = 4;
  localparam int DAM_EMICF_MD_LSB    = 2;
  localparam int DAM_STORE_WE_BIT    = 0;
  localparam int DAM_P1_WR_BIT     = 7;
  localparam int DAM_P1_RD_BIT     = 6;
  localparam int DAM_P1_ALE_BIT    = 3;

  // address map figures and strobe length
  localparam logic [7:0]  DAM_BIT_BASE  = 8'h20;
  localparam logic [15:0] DAM_PROG_TOP  = 16'hFBFF;
  localparam int          DAM_EXTERNAL_DATA_RAM_AW   = 12;
  localparam logic [1:0]  DAM_STB_LAST  = 2'h1;

  // external data memory modes
  typedef enum logic [1:0] {
    DAM_XM_ONCHIP     = 2'h0,
    DAM_XM_SPLIT      = 2'h1,
    DAM_XM_SPLIT_BANK = 2'h2,
    DAM_XM_OFFCHIP    = 2'h3
  } dam_xmode_t;

  // operand kinds decoded by the core
  typedef enum logic [2:0] {
    DAM_K_DIRECT   = 3'h0,
    DAM_K_INDIRECT = 3'h1,
    DAM_K_BIT      = 3'h2,
    DAM_K_PUSH     = 3'h3,
    DAM_K_POP      = 3'h4,
    DAM_K_XDPTR    = 3'h5,
    DAM_K_XPAGE    = 3'h6
  } dam_kind_t;

  typedef struct packed {
    dam_kind_t  kind;
    logic       write;
    logic       idx_b;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dam_req_t;

  typedef struct packed {
    logic       start;
    logic       write;
    logic       high_en;
    logic       mux;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dam_ext_req_t;

  typedef struct packed {
    logic [7:0] p4;
    logic [7:0] p3;
    logic [7:0] p2;
    logic [7:0] p1;
  } dam_port_bus_t;

endpackage : dam_pkg

// ===== tb/dam_addr_map_checker.sv
// port assertions for the data memory address map
// assumes one clock domain; bound onto every dam_addr_map
`timescale 1ns/100ps
module dam_addr_map_checker import dam_pkg::*; (
  // clock and reset
  input logic                   clk,
  input logic                   rstn,
  // core side
  input logic                   req_valid,
  input dam_pkg::dam_req_t      req,
  input logic                   req_ready,
  input logic                   rsp_valid,
  // program memory
  input logic [15:0]            prog_fetch_addr,
  input logic                   prog_fetch_reserved,
  input logic                   pmem_wr_valid,
  input logic                   pmem_wr_reserved,
  input logic [15:0]            pmem_wr_addr,
  // ports and pins
  input dam_pkg::dam_port_bus_t latch_out,
  input dam_pkg::dam_port_bus_t latch_oe,
  input dam_pkg::dam_port_bus_t port_output_mode,
  input dam_pkg::dam_port_bus_t pins_out,
  input dam_pkg::dam_port_bus_t pins_oe,
  input dam_pkg::dam_port_bus_t pins_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_fetch_reserved: assert property (
    $past(rstn) |-> prog_fetch_reserved == ($past(prog_fetch_addr) > DAM_PROG_TOP))
    else $error("fetch reserved flag wrong");
  a_store_window: assert property (
    pmem_wr_valid |-> pmem_wr_addr <= DAM_PROG_TOP && !pmem_wr_reserved)
    else $error("store write outside window");
  a_store_dropped: assert property (
    pmem_wr_reserved |-> pmem_wr_addr > DAM_PROG_TOP)
    else $error("store dropped below top");
  a_internal_answer: assert property (
    req_valid && req_ready && !(req.kind inside {DAM_K_XDPTR, DAM_K_XPAGE}) |=> rsp_valid)
    else $error("internal answer late");
  a_claim_bounded: assert property (
    $fell(req_ready) |-> ##[1:6] req_ready)
    else $error("pins held too long");
  a_idle_follow: assert property (
    req_ready && $past(req_ready) && $past(rstn) |-> pins_out == $past(latch_out) && pins_oe == $past(latch_oe))
    else $error("idle pins not on latches");
  a_input_released: assert property (
    !req_ready && pins_oe.p1[DAM_P1_RD_BIT] && !pins_out.p1[DAM_P1_RD_BIT] |-> pins_oe.p4 == 8'h00)
    else $error("data driven during read");
  a_strobe_width: assert property (
    $fell(pins_out.p1[DAM_P1_WR_BIT]) && !req_ready |-> (!pins_out.p1[DAM_P1_WR_BIT]) [*2] ##1 pins_out.p1[DAM_P1_WR_BIT])
    else $error("write strobe width wrong");
  a_mode_untouched: assert property (
    $past(rstn) |-> pins_mode == $past(port_output_mode))
    else $error("output mode disturbed");
endmodule : dam_addr_map_checker

bind dam_addr_map dam_addr_map_checker i_chk (
  .clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .prog_fetch_addr(prog_fetch_addr), .prog_fetch_reserved(prog_fetch_reserved), .pmem_wr_valid(pmem_wr_valid),
  .pmem_wr_reserved(pmem_wr_reserved), .pmem_wr_addr(pmem_wr_addr), .latch_out(latch_out), .latch_oe(latch_oe),
  .port_output_mode(port_output_mode), .pins_out(pins_out), .pins_oe(pins_oe), .pins_mode(pins_mode)
);

// ===== tb/dam_ext_mem.sv
// off-chip data memory seen through the interface pins
// assumes the bench resolves pins_in and tells it the bus form
`timescale 1ns/100ps
module dam_ext_mem import dam_pkg::*; (
  // clock
  input  logic                   clk,
  // pin view
  input  dam_pkg::dam_port_bus_t pins_out,
  input  dam_pkg::dam_port_bus_t pins_oe,
  input  logic                   mux_sel,
  // read drive onto the data lines
  output logic                   rd_en,
  output logic [7:0]             rd_byte
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lo_reg;
  logic [15:0] addr;

  // recognisable fill so stale reads show
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'hC3;
  end
  assign addr    = {pins_out.p2, mux_sel ? lo_reg : pins_out.p3};
  assign rd_en   = pins_oe.p1[DAM_P1_RD_BIT] && !pins_out.p1[DAM_P1_RD_BIT];
  assign rd_byte = mem[addr];
  always @(posedge clk) begin
    if (pins_oe.p1[DAM_P1_ALE_BIT] && pins_out.p1[DAM_P1_ALE_BIT]) lo_reg <= pins_out.p4;
    if (pins_oe.p1[DAM_P1_WR_BIT] && !pins_out.p1[DAM_P1_WR_BIT]) mem[addr] <= pins_out.p4;
  end
endmodule : dam_ext_mem

// ===== tb/testbench.sv
// self-checking bench for the data memory address map
// assumes the off-chip memory model and a pulled-up data bus
`timescale 1ns/100ps
module testbench import dam_pkg::*;;
  typedef struct packed {
    dam_kind_t  k;
    logic       w;
    logic       b;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } dam_row_t;
  localparam dam_kind_t kd = DAM_K_DIRECT, ki = DAM_K_INDIRECT, kb = DAM_K_BIT, ku = DAM_K_PUSH;
  localparam dam_kind_t ko = DAM_K_POP, kx = DAM_K_XDPTR, kg = DAM_K_XPAGE;
  // reads compare e; writes compare nothing
  dam_row_t rows [0:48] = '{
    '{kd,1'h1,1'h0,8'h10,8'h55,8'h00}, '{kd,1'h0,1'h0,8'h10,8'h00,8'h55}, '{kd,1'h0,1'h0,8'h81,8'h00,8'h07},
    '{kd,1'h0,1'h0,8'hAA,8'h00,8'h00}, '{kd,1'h1,1'h0,8'h00,8'h90,8'h00}, '{ki,1'h1,1'h0,8'h00,8'hA5,8'h00},
    '{ki,1'h0,1'h0,8'h00,8'h00,8'hA5}, '{kd,1'h0,1'h0,8'h90,8'h00,8'h00}, '{ku,1'h1,1'h0,8'h00,8'h3C,8'h00},
    '{kd,1'h0,1'h0,8'h08,8'h00,8'h3C}, '{kd,1'h0,1'h0,8'h81,8'h00,8'h08}, '{ko,1'h0,1'h0,8'h00,8'h00,8'h3C},
    '{kd,1'h0,1'h0,8'h81,8'h00,8'h07}, '{kd,1'h1,1'h0,8'h19,8'h40,8'h00}, '{kd,1'h1,1'h0,8'h40,8'h77,8'h00},
    '{kd,1'h1,1'h0,8'hD0,8'h18,8'h00}, '{ki,1'h0,1'h1,8'h00,8'h00,8'h77}, '{kd,1'h1,1'h0,8'hD0,8'h00,8'h00},
    '{kd,1'h1,1'h0,8'h22,8'h08,8'h00}, '{kb,1'h0,1'h0,8'h13,8'h00,8'h01}, '{kb,1'h1,1'h0,8'h13,8'h00,8'h00},
    '{kd,1'h0,1'h0,8'h22,8'h00,8'h00}, '{kd,1'h1,1'h0,8'h82,8'h34,8'h00}, '{kd,1'h1,1'h0,8'h83,8'h02,8'h00},
    '{kx,1'h1,1'h0,8'h00,8'h9A,8'h00}, '{kx,1'h0,1'h0,8'h00,8'h00,8'h9A}, '{kd,1'h0,1'h0,8'h83,8'h00,8'h02},
    '{kd,1'h1,1'h0,8'h00,8'h34,8'h00}, '{kd,1'h1,1'h0,8'hAA,8'h02,8'h00}, '{kg,1'h0,1'h0,8'h00,8'h00,8'h9A},
    '{kd,1'h1,1'h0,8'h85,8'h0C,8'h00}, '{kd,1'h1,1'h0,8'h83,8'h12,8'h00}, '{kx,1'h1,1'h0,8'h00,8'h6B,8'h00},
    '{kx,1'h0,1'h0,8'h00,8'h00,8'h6B}, '{kd,1'h1,1'h0,8'h82,8'h35,8'h00}, '{kx,1'h0,1'h0,8'h00,8'h00,8'hF6},
    '{kd,1'h1,1'h0,8'h85,8'h1C,8'h00}, '{kd,1'h1,1'h0,8'h82,8'h34,8'h00}, '{kx,1'h0,1'h0,8'h00,8'h00,8'h6B},
    '{kd,1'h1,1'h0,8'h85,8'h14,8'h00}, '{kx,1'h0,1'h0,8'h00,8'h00,8'h6B}, '{kd,1'h1,1'h0,8'h83,8'h02,8'h00},
    '{kx,1'h0,1'h0,8'h00,8'h00,8'h9A}, '{kd,1'h1,1'h0,8'h85,8'h08,8'h00}, '{kx,1'h0,1'h0,8'h00,8'h00,8'h9A},
    '{kd,1'h1,1'h0,8'h83,8'h12,8'h00}, '{kx,1'h0,1'h0,8'h00,8'h00,8'h6B}, '{kd,1'h1,1'h0,8'h85,8'h00,8'h00},
    '{kx,1'h0,1'h0,8'h00,8'h00,8'h9A}};
  logic clk, rstn, req_valid, req_ready, rsp_valid, rsp_bit, mux_sel, rd_en, got_b;
  logic prog_fetch_reserved, pmem_wr_valid, pmem_wr_reserved;
  logic [7:0] rsp_data, pmem_wr_data, rd_byte, got_d;
  logic [15:0] prog_fetch_addr, pmem_wr_addr;
  logic [23:0] pm_last;
  dam_req_t req;
  dam_port_bus_t latch_out, latch_oe, port_output_mode, pins_in, pins_out, pins_oe, pins_mode;
  int errors, total_checks, cycles, ale_cnt, pm_res;

  dam_addr_map i_dut (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_bit(rsp_bit), .prog_fetch_addr(prog_fetch_addr),
    .prog_fetch_reserved(prog_fetch_reserved), .pmem_wr_valid(pmem_wr_valid), .pmem_wr_reserved(pmem_wr_reserved),
    .pmem_wr_addr(pmem_wr_addr), .pmem_wr_data(pmem_wr_data), .latch_out(latch_out), .latch_oe(latch_oe),
    .port_output_mode(port_output_mode), .pins_in(pins_in), .pins_out(pins_out), .pins_oe(pins_oe),
    .pins_mode(pins_mode));
  dam_ext_mem i_mem (.clk(clk), .pins_out(pins_out), .pins_oe(pins_oe), .mux_sel(mux_sel), .rd_en(rd_en),
    .rd_byte(rd_byte));
  // undriven lines float to the pull-up level
  assign pins_in = (pins_out & pins_oe) | (~pins_oe & {rd_en ? rd_byte : 8'hFF, 24'hFF_FFFF});

  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (pins_oe.p1[DAM_P1_ALE_BIT] && pins_out.p1[DAM_P1_ALE_BIT]) ale_cnt++;
    if (pmem_wr_valid) pm_last <= {pmem_wr_addr, pmem_wr_data};
    if (pmem_wr_reserved) pm_res++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one request from a falling edge; leaves a spare cycle so strobes never re-rise in one step
  task acc(input dam_kind_t k, input logic w, input logic b, input logic [7:0] a, input logic [7:0] d);
    int n;
    if (k == kd && w && a == DAM_SFR_EMICF) mux_sel = !d[DAM_EMICF_MUX_BIT];
    req_valid = 1'h1;
    req = '{k, w, b, a, d};
    n = 0;
    while (req_ready !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'h0;
    n = 0;
    while (rsp_valid !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(n < 20, 1'h1, "answer missing");
    got_d = rsp_data;
    got_b = rsp_bit;
    @(negedge clk);
  endtask : acc

  task give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    req_valid = 1'h0;
    req = '0;
    prog_fetch_addr = 16'h0000;
    mux_sel = 1'h1;
    latch_out = 32'hFFFF_FFFF;
    latch_oe = 32'hFFFF_FF37;
    port_output_mode = 32'h0F0F_F0F0;
    repeat (12) @(negedge clk);
    rstn = 1'h1;
    for (int i = 0; i < 49; i++) begin
      acc(rows[i].k, rows[i].w, rows[i].b, rows[i].a, rows[i].d);
      if (!rows[i].w && rows[i].k == kb) chk(got_b, rows[i].e[0], "bit read");
      else if (!rows[i].w) chk(got_d, rows[i].e, "byte read");
    end
    chk(ale_cnt, 4, "address latch pulses");
    chk(pins_mode, port_output_mode, "output mode");
    chk(pins_out, latch_out, "parked pins");
    $display("table rows done");
    acc(kd, 1'h1, 1'h0, DAM_SFR_STORE_CTL, 8'h01);
    acc(kd, 1'h1, 1'h0, DAM_SFR_PTR_LOW, 8'h34);
    // pointer high byte still holds 0x12 from the table
    acc(kx, 1'h1, 1'h0, 8'h00, 8'h11);
    chk(pm_last, 24'h12_3411, "store write");
    acc(kd, 1'h1, 1'h0, DAM_SFR_PTR_HIGH, 8'hFC);
    acc(kd, 1'h1, 1'h0, DAM_SFR_PTR_LOW, 8'h00);
    acc(kx, 1'h1, 1'h0, 8'h00, 8'h22);
    chk(pm_res, 1, "reserved store");
    acc(kd, 1'h1, 1'h0, DAM_SFR_STORE_CTL, 8'h00);
    acc(kd, 1'h1, 1'h0, DAM_SFR_PTR_HIGH, 8'h02);
    acc(kd, 1'h1, 1'h0, DAM_SFR_PTR_LOW, 8'h34);
    acc(kx, 1'h0, 1'h0, 8'h00, 8'h00);
    chk(got_d, 8'h9A, "data ram untouched");
    // split without bank select: page byte stays off port 2, latch 0xFF shows instead
    acc(kd, 1'h1, 1'h0, DAM_SFR_EMICF, 8'h14);
    acc(kd, 1'h1, 1'h0, DAM_SFR_PAGE, 8'h12);
    acc(kg, 1'h0, 1'h0, 8'h00, 8'h00);
    chk(got_d, 8'hF7, "split page read");
    $display("program store done");
    foreach (rows[i]) begin
      if (i < 3) begin
        prog_fetch_addr = i == 0 ? 16'h0000 : (i == 1 ? DAM_PROG_TOP : 16'hFC00);
        @(negedge clk);
        chk(prog_fetch_reserved, prog_fetch_addr > 16'hFBFF, "fetch reserved");
      end
    end
    $display("fetch range done");
    acc(kd, 1'h1, 1'h0, DAM_SFR_STACK, 8'h30);
    acc(kd, 1'h1, 1'h0, DAM_SFR_PAGE, 8'h55);
    rstn = 1'h0;
    @(negedge clk);
    chk(req_ready, 1'h1, "ready in reset");
    chk(pins_oe, 32'h0000_0000, "pins released in reset");
    rstn = 1'h1;
    // request right at the first edge after release
    acc(kd, 1'h0, 1'h0, DAM_SFR_STACK, 8'h00);
    chk(got_d, 8'h07, "stack pointer reset");
    acc(kd, 1'h0, 1'h0, DAM_SFR_PAGE, 8'h00);
    chk(got_d, 8'h00, "page reset");
    $display("mid-run reset done");
    give_verdict();
  end
endmodule : testbench
